// ===== shared/etm_pkg.sv
/*
  Shared constants and types of the egress tributary mapper control.
  Assumes register indices are printed offsets; byte address is 4x.
*/
package etm_pkg;

  localparam int NUM_TRIB = 84;

  // register indices
  localparam logic [11:0] IDX_TRIB_BASE = 12'hE00;
  localparam logic [11:0] IDX_TS_PAGE   = 12'hE61;
  localparam logic [11:0] IDX_TS_CTL    = 12'hE62;
  localparam logic [11:0] IDX_TS_ADDR   = 12'hE63;
  localparam logic [11:0] IDX_TS_DATA   = 12'hE64;
  localparam logic [11:0] IDX_EGR_CFG   = 12'hE70;

  // bus index fields of the tributary block
  localparam int BUS_GRP_LSB = 5;
  localparam int BUS_TU_LSB  = 3;

  // tributary control fields
  localparam int NARROW_BIT = 7;
  localparam int T1_BIT     = 6;
  localparam int TRIBUTARY_PROVISIONED_BIT   = 5;
  localparam int PTRDIS_BIT = 2;
  localparam int TVT_BIT    = 1;
  localparam int LINE_ADD_OUTPUT_ENABLE_BIT   = 0;
  localparam logic [7:0] TRIB_RESET = 8'hC0;
  localparam logic [7:0] TRIB_WMASK = 8'hE7;

  // indirect control, address and egress configuration fields
  localparam int CTL_RNW_BIT  = 6;
  localparam int CTL_PAGE_BIT = 5;
  localparam int TSA_TUG3_LSB = 6;
  localparam int TSA_TUG2_LSB = 3;
  localparam logic [7:0] TS_ADDR_RESET = 8'h49;
  localparam int TSEN_BIT    = 0;
  localparam int PPBYP_BIT   = 1;
  localparam int PTRBYP_LSB  = 2;

  // indirect access time in clk_sys cycles
  localparam logic [1:0] TS_ACCESS_CYC = 2'h2;

  typedef enum logic [1:0] {
    ETM_MAP_ZERO, ETM_MAP_ASYNC, ETM_MAP_BSYNC, ETM_MAP_TVT
  } etm_map_e;

  typedef enum logic [1:0] {
    ETM_E1_TU12, ETM_T1_TU12, ETM_T1_NARROW_TRIBUTARY_SELECT
  } etm_trib_e;

  typedef enum logic {ETM_TS_IDLE, ETM_TS_RUN} etm_ts_state_e;

endpackage : etm_pkg

// ===== hdl/etm_tsram.sv
/*
  Two-page time-switch configuration store with its indirect access engine.
  Assumes start is a one-cycle pulse given only while busy is low.
*/
`timescale 1ns/100ps
`default_nettype none
module etm_tsram
  import etm_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       rnw,
  input  wire logic       page,
  input  wire logic       acc_ok,
  input  wire logic [6:0] acc_index,
  input  wire logic [6:0] wr_word,
  input  wire logic       act_page,
  input  wire logic [6:0] lk_index,
  output logic            busy,
  output logic            rd_done,
  output logic      [6:0] rd_word,
  output logic      [6:0] lk_word
);

  logic [6:0]    mem [2][NUM_TRIB];
  etm_ts_state_e state;
  logic [1:0]    cnt;
  logic          op_rnw;
  logic          op_page;
  logic          op_ok;
  logic [6:0]    op_idx;
  logic [6:0]    op_word;
  logic          last;

  assign last = (state == ETM_TS_RUN) && (cnt == 2'h0);

  // ----------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state   <= ETM_TS_IDLE;
      cnt     <= 2'h0;
      busy    <= 1'b0;
      rd_done <= 1'b0;
      rd_word <= 7'h00;
      op_rnw  <= 1'b1;
      op_page <= 1'b0;
      op_ok   <= 1'b0;
      op_idx  <= 7'h00;
      op_word <= 7'h00;
    end else begin
      rd_done <= 1'b0;
      case (state)
        ETM_TS_IDLE: begin
          if (start) begin
            state   <= ETM_TS_RUN;
            busy    <= 1'b1;
            cnt     <= TS_ACCESS_CYC - 2'h1;
            op_rnw  <= rnw;
            op_page <= page;
            op_ok   <= acc_ok;
            op_idx  <= acc_index;
            op_word <= wr_word;
          end
        end
        ETM_TS_RUN: begin
          if (cnt == 2'h0) begin
            state   <= ETM_TS_IDLE;
            busy    <= 1'b0;
            rd_done <= op_rnw;
            if (op_rnw) begin
              // out of range addresses read as zero
              rd_word <= op_ok ? mem[op_page][op_idx] : 7'h00;
            end
          end else begin
            cnt <= cnt - 2'h1;
          end
        end
        default: state <= ETM_TS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------
  // storage and active-page lookup
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < 2; p++) begin
        for (int i = 0; i < NUM_TRIB; i++) begin
          mem[p][i] <= 7'h00;
        end
      end
    end else if (last && !op_rnw && op_ok) begin
      mem[op_page][op_idx] <= op_word;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lk_word <= 7'h00;
    end else begin
      lk_word <= mem[act_page][lk_index];
    end
  end

  AST_BUSY_SEQ: assert property (
    @(posedge clk_sys) disable iff (rst)
    (start && !busy) |=> busy ##1 busy ##1
      (!busy && (rd_done == $past(rnw, 3))))
    else $error("indirect access busy window wrong");

endmodule : etm_tsram
`default_nettype wire

// ===== hdl/etm_ctrl.sv
/*
  Egress tributary mapper control: per-tributary registers, time-switch
  indirect access and per-column control towards the line add bus.
  Assumes an Avalon-MM master on clk_sys, and column timing plus the
  byte-sync mapper enables from same-clock logic.
*/
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------
// Overview of operation
// - output enable low tristates tributary columns
// - output enable pin mirrors bit per column
// - transparent select picks system bus VT
// - pointer disable aligns on V5, else realign
// - global SPE bypass forces pointer disable
// - unprovisioned tributary maps zero payload unless TVT or byte-sync set
// - transparent select beats byte-sync enable
// - byte-sync enable gives byte-synchronous mapping
// - provisioned alone gives bit-asynchronous mapping
// - nothing selected: overhead only, zero payload
// - group uses first narrow bit, others read-only
// - control at E00 plus group, TUG-2, TU
// - active page selects lookup page
// - control register write starts indirect access
// - page bit picks page of indirect access
// - read-not-write picks access kind, resets one
// - busy high from start until done
// - switch link flagged valid only when switch enabled; spe and link lookup always driven
// ----------------------------------------------------------
module etm_ctrl
  import etm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [13:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic  [3:0] avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [83:0] byte_sync_mapper_enable,
  input  wire logic        col_valid,
  input  wire logic  [1:0] col_tug3,
  input  wire logic  [2:0] col_tug2,
  input  wire logic  [2:0] col_tu,
  output logic             line_add_output_enable,
  output logic             line_add_drive_en,
  output logic             trib_active,
  output var etm_trib_e    trib_type,
  output var etm_map_e     map_mode,
  output logic             tvt_select,
  output logic             pointer_disable,
  output logic             egress_pointer_processor_bypass,
  output logic             ts_link_valid,
  output logic       [1:0] ts_int_spe,
  output logic       [4:0] ts_int_link
);

  function automatic logic [6:0] trib_idx(
    input logic [1:0] g,
    input logic [2:0] t2,
    input logic [1:0] tu
  );
    trib_idx = 7'(g * 28 + t2 * 4 + tu);
  endfunction : trib_idx

  logic [7:0]  trib [NUM_TRIB];
  logic        active_switch_page;
  logic        ctl_rnw;
  logic        ctl_page;
  logic [7:0]  ts_addr;
  logic [6:0]  ts_data;
  logic [4:0]  egr_cfg;
  logic [7:0]  next_rdata;

  logic [11:0] idx;
  logic [7:0]  wd;
  logic        req;
  logic        wr_lo;
  logic        trib_hit;
  logic [6:0]  bus_ti;
  logic [6:0]  bus_first;

  logic        ts_busy;
  logic        ts_start;
  logic        ts_rd_done;
  logic [6:0]  ts_rd_word;
  logic [6:0]  ts_lk_word;
  logic [1:0]  a_g;
  logic [2:0]  a_t2;
  logic [2:0]  a_tu;
  logic        acc_ok;
  logic [6:0]  acc_index;

  logic        col_ok;
  logic [6:0]  col_ti;
  logic [6:0]  col_first;
  logic [7:0]  cur;
  logic        cur_narrow;
  logic        cur_bs;
  logic        cur_live;
  etm_map_e    next_mode;

  // ----------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------
  assign idx   = avs_address[13:2];
  assign wd    = avs_writedata[7:0];
  assign req   = avs_read | avs_write;
  // only the low byte lane carries register data
  assign wr_lo = avs_write & ~avs_waitrequest & avs_byteenable[0];

  assign trib_hit = (idx[11:7] == IDX_TRIB_BASE[11:7])
                 && (idx[BUS_GRP_LSB +: 2] != 2'h3)
                 && (idx[2:0] != 3'h7);
  assign bus_ti    = trib_idx(idx[BUS_GRP_LSB +: 2], idx[2:0],
                              idx[BUS_TU_LSB +: 2]);
  assign bus_first = trib_idx(idx[BUS_GRP_LSB +: 2], idx[2:0], 2'h0);

  // one wait cycle per access, so every answer takes two edges
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
    end
  end

  // ----------------------------------------------------------
  // read path
  // ----------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (trib_hit) begin
      next_rdata = trib[bus_ti];
      next_rdata[NARROW_BIT] = trib[bus_first][NARROW_BIT];
    end else begin
      case (idx)
        IDX_TS_PAGE: next_rdata = {7'h00, active_switch_page};
        IDX_TS_CTL:  next_rdata = {ts_busy, ctl_rnw, ctl_page, 5'h00};
        IDX_TS_ADDR: next_rdata = ts_addr;
        IDX_TS_DATA: next_rdata = {1'b0, ts_data};
        IDX_EGR_CFG: next_rdata = {3'h0, egr_cfg};
        default:     next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, next_rdata};
    end
  end

  // ----------------------------------------------------------
  // tributary control registers
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_TRIB; i++) begin
        trib[i] <= TRIB_RESET;
      end
    end else if (wr_lo && trib_hit) begin
      if (idx[BUS_TU_LSB +: 2] == 2'h0) begin
        trib[bus_ti] <= wd & TRIB_WMASK;
      end else begin
        // narrow bit of later TUs stays read-only
        trib[bus_ti] <= {trib[bus_ti][NARROW_BIT],
                         wd[6:0] & TRIB_WMASK[6:0]};
      end
    end
  end

  // ----------------------------------------------------------
  // page, address and egress configuration registers
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      active_switch_page <= 1'b0;
      ts_addr            <= TS_ADDR_RESET;
      egr_cfg            <= 5'h00;
    end else if (wr_lo) begin
      case (idx)
        IDX_TS_PAGE: active_switch_page <= wd[0];
        IDX_TS_ADDR: ts_addr <= wd;
        IDX_EGR_CFG: egr_cfg <= wd[4:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // indirect time-switch access
  // ----------------------------------------------------------
  // a trigger while busy is dropped rather than corrupting the access
  assign ts_start = wr_lo && (idx == IDX_TS_CTL) && !ts_busy;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_rnw  <= 1'b1;
      ctl_page <= 1'b0;
    end else if (ts_start) begin
      ctl_rnw  <= wd[CTL_RNW_BIT];
      ctl_page <= wd[CTL_PAGE_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ts_data <= 7'h00;
    end else if (ts_rd_done) begin
      ts_data <= ts_rd_word;
    end else if (wr_lo && (idx == IDX_TS_DATA)) begin
      ts_data <= wd[6:0];
    end
  end

  assign a_g  = ts_addr[TSA_TUG3_LSB +: 2];
  assign a_t2 = ts_addr[TSA_TUG2_LSB +: 3];
  assign a_tu = ts_addr[2:0];
  assign acc_ok = (a_g != 2'h0) && (a_t2 != 3'h0)
               && (a_tu != 3'h0) && (a_tu <= 3'h4);
  assign acc_index = trib_idx(2'(a_g - 2'h1), 3'(a_t2 - 3'h1),
                              2'(a_tu - 3'h1));

  etm_tsram u_tsram (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .start     (ts_start),
    .rnw       (wd[CTL_RNW_BIT]),
    .page      (wd[CTL_PAGE_BIT]),
    .acc_ok    (acc_ok),
    .acc_index (acc_index),
    .wr_word   (ts_data),
    .act_page  (active_switch_page),
    .lk_index  (col_ok ? col_ti : 7'h00),
    .busy      (ts_busy),
    .rd_done   (ts_rd_done),
    .rd_word   (ts_rd_word),
    .lk_word   (ts_lk_word)
  );

  assign ts_int_spe  = ts_lk_word[6:5];
  assign ts_int_link = ts_lk_word[4:0];

  // ----------------------------------------------------------
  // per-column lookup
  // ----------------------------------------------------------
  assign col_ok = col_valid && (col_tug3 != 2'h0) && (col_tug2 != 3'h0)
               && (col_tu != 3'h0) && (col_tu <= 3'h4);
  assign col_ti    = trib_idx(2'(col_tug3 - 2'h1), 3'(col_tug2 - 3'h1),
                              2'(col_tu - 3'h1));
  assign col_first = trib_idx(2'(col_tug3 - 2'h1), 3'(col_tug2 - 3'h1),
                              2'h0);
  assign cur        = trib[col_ti];
  assign cur_narrow = trib[col_first][NARROW_BIT];
  assign cur_bs     = byte_sync_mapper_enable[col_ti];
  // TU #4 exists only in TU-11 groups
  assign cur_live   = cur_narrow || (col_tu != 3'h4);

  always_comb begin
    if (cur[TVT_BIT]) begin
      next_mode = ETM_MAP_TVT;
    end else if (cur_bs) begin
      next_mode = ETM_MAP_BSYNC;
    end else if (cur[TRIBUTARY_PROVISIONED_BIT]) begin
      next_mode = ETM_MAP_ASYNC;
    end else begin
      next_mode = ETM_MAP_ZERO;
    end
  end

  // ----------------------------------------------------------
  // column outputs, one cycle after the column index
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_add_output_enable <= 1'b0;
      line_add_drive_en      <= 1'b0;
      trib_active            <= 1'b0;
      trib_type              <= ETM_T1_NARROW_TRIBUTARY_SELECT;
      map_mode               <= ETM_MAP_ZERO;
      tvt_select             <= 1'b0;
      pointer_disable        <= 1'b0;
      ts_link_valid          <= 1'b0;
    end else begin
      line_add_output_enable <= col_ok && cur_live && cur[LINE_ADD_OUTPUT_ENABLE_BIT];
      line_add_drive_en      <= col_ok && cur_live && cur[LINE_ADD_OUTPUT_ENABLE_BIT];
      trib_active            <= col_ok && cur_live;
      if (cur_narrow) begin
        trib_type <= ETM_T1_NARROW_TRIBUTARY_SELECT;
      end else begin
        trib_type <= cur[T1_BIT] ? ETM_T1_TU12 : ETM_E1_TU12;
      end
      map_mode   <= col_ok ? next_mode : ETM_MAP_ZERO;
      tvt_select <= col_ok && cur[TVT_BIT];
      pointer_disable <= col_ok && (cur[PTRDIS_BIT]
                         || egr_cfg[PTRBYP_LSB + 32'(col_tug3) - 1]);
      ts_link_valid   <= col_ok && egr_cfg[TSEN_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      egress_pointer_processor_bypass <= 1'b0;
    end else begin
      egress_pointer_processor_bypass <= egr_cfg[PPBYP_BIT];
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  AST_DRIVE_MIRROR: assert property (
    @(posedge clk_sys) disable iff (rst)
    line_add_drive_en == line_add_output_enable)
    else $error("drive enable and enable pin disagree");

  AST_LINE_ADD_OUTPUT_ENABLE_OFF: assert property (
    @(posedge clk_sys) disable iff (rst)
    (col_ok && !cur[LINE_ADD_OUTPUT_ENABLE_BIT]) |=> !line_add_drive_en)
    else $error("column driven with enable bit clear");

  AST_TVT_PRIORITY: assert property (
    @(posedge clk_sys) disable iff (rst)
    (col_ok && cur[TVT_BIT]) |=> (map_mode == ETM_MAP_TVT) && tvt_select)
    else $error("transparent select lost priority");

  AST_BSYNC: assert property (
    @(posedge clk_sys) disable iff (rst)
    (col_ok && !cur[TVT_BIT] && cur_bs) |=> map_mode == ETM_MAP_BSYNC)
    else $error("byte-sync mapping not chosen");

  AST_ASYNC: assert property (
    @(posedge clk_sys) disable iff (rst)
    (col_ok && !cur[TVT_BIT] && !cur_bs && cur[TRIBUTARY_PROVISIONED_BIT])
      |=> map_mode == ETM_MAP_ASYNC)
    else $error("async mapping not chosen");

  AST_ZERO_FILL: assert property (
    @(posedge clk_sys) disable iff (rst)
    (col_ok && !cur[TVT_BIT] && !cur_bs && !cur[TRIBUTARY_PROVISIONED_BIT])
      |=> map_mode == ETM_MAP_ZERO)
    else $error("idle tributary not zero filled");

  AST_PTR_BYPASS: assert property (
    @(posedge clk_sys) disable iff (rst)
    (col_ok && egr_cfg[PTRBYP_LSB + 32'(col_tug3) - 1]) |=> pointer_disable)
    else $error("global bypass did not disable pointer");

  AST_TU4_IDLE: assert property (
    @(posedge clk_sys) disable iff (rst)
    (col_ok && (col_tu == 3'h4) && !cur_narrow)
      |=> !trib_active && (trib_type != ETM_T1_NARROW_TRIBUTARY_SELECT))
    else $error("TU #4 active in a TU-12 group");

  AST_TS_DISABLED: assert property (
    @(posedge clk_sys) disable iff (rst)
    !egr_cfg[TSEN_BIT] |=> !ts_link_valid)
    else $error("switch link used while disabled");

endmodule : etm_ctrl
`default_nettype wire

// ===== verification/etm_line_side.sv
/*
  Line-side column source standing in for the add bus timing logic.
  Assumes the bench names one tributary column at a time through req.
*/
`timescale 1ns/100ps
`default_nettype none
module etm_line_side (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic  [1:0] req_tug3,
  input  wire logic  [2:0] req_tug2,
  input  wire logic  [2:0] req_tu,
  input  wire logic [83:0] bsync_cfg,
  output logic             col_valid,
  output logic       [1:0] col_tug3,
  output logic       [2:0] col_tug2,
  output logic       [2:0] col_tu,
  output logic      [83:0] byte_sync_mapper_enable
);
  // ----------------------------------------------------------
  // column timing
  // ----------------------------------------------------------
  // outside a column the index lines toggle, so stale values never pass
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      col_valid <= 1'b0;
      col_tug3  <= 2'h0;
      col_tug2  <= 3'h0;
      col_tu    <= 3'h0;
    end else if (req) begin
      col_valid <= 1'b1;
      col_tug3  <= req_tug3;
      col_tug2  <= req_tug2;
      col_tu    <= req_tu;
    end else begin
      col_valid <= 1'b0;
      col_tug3  <= ~col_tug3;
      col_tug2  <= ~col_tug2;
      col_tu    <= ~col_tu;
    end
  end

  // ----------------------------------------------------------
  // byte-sync mapper enables
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      byte_sync_mapper_enable <= '0;
    end else begin
      byte_sync_mapper_enable <= bsync_cfg;
    end
  end
endmodule : etm_line_side
`default_nettype wire

// ===== verification/tb_egress_tributary_mapper_control.sv
/*
  Self-checking bench of the egress tributary mapper control.
  Assumes etm_ctrl as top and the line-side model beside it.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_egress_tributary_mapper_control
  import etm_pkg::*;
;
  logic        clk_sys;
  logic        rst;
  logic [13:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic  [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [83:0] byte_sync_mapper_enable;
  logic [83:0] bsync_cfg;
  logic        col_valid;
  logic  [1:0] col_tug3;
  logic  [2:0] col_tug2;
  logic  [2:0] col_tu;
  logic        req;
  logic  [1:0] req_tug3;
  logic  [2:0] req_tug2;
  logic  [2:0] req_tu;
  logic        line_add_output_enable;
  logic        line_add_drive_en;
  logic        trib_active;
  etm_trib_e   trib_type;
  etm_map_e    map_mode;
  logic        tvt_select;
  logic        pointer_disable;
  logic        egress_pointer_processor_bypass;
  logic        ts_link_valid;
  logic  [1:0] ts_int_spe;
  logic  [4:0] ts_int_link;
  int          err_count = 0;
  int          samples_checked = 0;

  etm_ctrl u_etm_ctrl (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .byte_sync_mapper_enable(byte_sync_mapper_enable),
    .col_valid(col_valid), .col_tug3(col_tug3), .col_tug2(col_tug2),
    .col_tu(col_tu), .line_add_output_enable(line_add_output_enable),
    .line_add_drive_en(line_add_drive_en), .trib_active(trib_active),
    .trib_type(trib_type), .map_mode(map_mode), .tvt_select(tvt_select),
    .pointer_disable(pointer_disable),
    .egress_pointer_processor_bypass(egress_pointer_processor_bypass),
    .ts_link_valid(ts_link_valid), .ts_int_spe(ts_int_spe),
    .ts_int_link(ts_int_link)
  );

  etm_line_side u_etm_line_side (
    .clk_sys(clk_sys), .rst(rst), .req(req), .req_tug3(req_tug3),
    .req_tug2(req_tug2), .req_tu(req_tu), .bsync_cfg(bsync_cfg),
    .col_valid(col_valid), .col_tug3(col_tug3), .col_tug2(col_tug2),
    .col_tu(col_tu), .byte_sync_mapper_enable(byte_sync_mapper_enable)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic summarize();
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  // request held until waitrequest is sampled low at a rising edge;
  // only the watchdog ends a wait that never answers
  task automatic acc(input logic wr, input logic [11:0] idx,
                     input logic [7:0] wd, input logic [3:0] be,
                     output logic [7:0] rd);
    avs_address    <= {idx, 2'b00};
    avs_write      <= wr;
    avs_read       <= ~wr;
    avs_writedata  <= {24'h000000, wd};
    avs_byteenable <= be;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask : acc

  task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    acc(1'b1, idx, wd, 4'hF, d);
  endtask : wr

  task automatic rchk(input logic [11:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    acc(1'b0, idx, 8'h00, 4'hF, d);
    check($sformatf("register %h", idx), exp, d);
  endtask : rchk

  task automatic wait_idle();
    logic [7:0] d;
    int n;
    n = 0;
    do begin
      acc(1'b0, 12'hE62, 8'h00, 4'hF, d);
      n++;
    end while (d[7] !== 1'b0 && n < 20);
    check("busy", 16'h0000, d[7]);
  endtask : wait_idle

  function automatic logic [8:0] cv(logic en, logic drv, logic act,
                                    etm_trib_e ty, etm_map_e m,
                                    logic tv, logic pd);
    return {en, drv, act, ty, m, tv, pd};
  endfunction : cv

  // one column of a tributary; outputs land one cycle after it
  task automatic col(input logic [1:0] g, input logic [2:0] t2,
                     input logic [2:0] tu, input logic [8:0] exp,
                     input logic do_ts, input logic [7:0] ts_exp);
    req      <= 1'b1;
    req_tug3 <= g;
    req_tug2 <= t2;
    req_tu   <= tu;
    @(posedge clk_sys);
    req <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check("column", exp, {line_add_output_enable, line_add_drive_en,
          trib_active, trib_type, map_mode, tvt_select, pointer_disable});
    if (do_ts) check("switch", ts_exp, {ts_link_valid, ts_int_spe,
                     ts_int_link});
    @(posedge clk_sys);
  endtask : col

  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  initial begin
    logic [7:0] d;
    rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    bsync_cfg = '0;
    req = 1'b0;
    req_tug3 = 2'h0;
    req_tug2 = 3'h0;
    req_tu = 3'h0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rchk(12'hE00, 8'hC0);
    rchk(12'hE5E, 8'hC0);
    rchk(12'hE61, 8'h00);
    rchk(12'hE62, 8'h40);
    rchk(12'hE63, 8'h49);
    rchk(12'hE64, 8'h00);
    wr(12'hE90, 8'hFF);
    rchk(12'hE90, 8'h00);
    wr(12'hE08, 8'hFF);
    rchk(12'hE08, 8'hE7);
    wr(12'hE00, 8'h00);
    rchk(12'hE00, 8'h00);
    rchk(12'hE08, 8'h67);
    acc(1'b1, 12'hE00, 8'h21, 4'h0, d);
    rchk(12'hE00, 8'h00);
    // mapping priority on tributary 1.1.1
    col(2'h1, 3'h1, 3'h1, cv(0, 0, 1, ETM_E1_TU12, ETM_MAP_ZERO, 0, 0),
        1'b0, 8'h00);
    wr(12'hE00, 8'h01);
    col(2'h1, 3'h1, 3'h1, cv(1, 1, 1, ETM_E1_TU12, ETM_MAP_ZERO, 0, 0),
        1'b0, 8'h00);
    wr(12'hE00, 8'h21);
    col(2'h1, 3'h1, 3'h1, cv(1, 1, 1, ETM_E1_TU12, ETM_MAP_ASYNC, 0, 0),
        1'b0, 8'h00);
    wr(12'hE00, 8'h25);
    bsync_cfg <= '1;
    col(2'h1, 3'h1, 3'h1, cv(1, 1, 1, ETM_E1_TU12, ETM_MAP_BSYNC, 0, 1),
        1'b0, 8'h00);
    wr(12'hE00, 8'h27);
    col(2'h1, 3'h1, 3'h1, cv(1, 1, 1, ETM_E1_TU12, ETM_MAP_TVT, 1, 1),
        1'b0, 8'h00);
    bsync_cfg <= '0;
    wr(12'hE00, 8'h23);
    col(2'h1, 3'h1, 3'h1, cv(1, 1, 1, ETM_E1_TU12, ETM_MAP_TVT, 1, 0),
        1'b0, 8'h00);
    wr(12'hE70, 8'h04);
    col(2'h1, 3'h1, 3'h1, cv(1, 1, 1, ETM_E1_TU12, ETM_MAP_TVT, 1, 1),
        1'b0, 8'h00);
    wr(12'hE70, 8'h00);
    wr(12'hE00, 8'h61);
    col(2'h1, 3'h1, 3'h1, cv(1, 1, 1, ETM_T1_TU12, ETM_MAP_ASYNC, 0, 0),
        1'b0, 8'h00);
    wr(12'hE00, 8'hA1);
    wr(12'hE18, 8'h21);
    col(2'h1, 3'h1, 3'h4, cv(1, 1, 1, ETM_T1_NARROW_TRIBUTARY_SELECT, ETM_MAP_ASYNC, 0, 0),
        1'b0, 8'h00);
    wr(12'hE00, 8'h21);
    rchk(12'hE18, 8'h21);
    col(2'h1, 3'h1, 3'h4, cv(0, 0, 0, ETM_E1_TU12, ETM_MAP_ASYNC, 0, 0),
        1'b0, 8'h00);
    wr(12'hE2A, 8'h21);
    col(2'h2, 3'h3, 3'h2, cv(1, 1, 1, ETM_T1_NARROW_TRIBUTARY_SELECT, ETM_MAP_ASYNC, 0, 0),
        1'b0, 8'h00);
    wr(12'hE70, 8'h02);
    @(posedge clk_sys);
    check("bypass", 16'h0001, egress_pointer_processor_bypass);
    wr(12'hE70, 8'h00);
    // time-switch store through indirect access
    wr(12'hE64, 8'h25);
    wr(12'hE62, 8'h20);
    wait_idle();
    wr(12'hE61, 8'h01);
    wr(12'hE64, 8'h3C);
    wr(12'hE62, 8'h00);
    wait_idle();
    wr(12'hE62, 8'h60);
    wait_idle();
    rchk(12'hE64, 8'h25);
    wr(12'hE62, 8'h40);
    wait_idle();
    rchk(12'hE64, 8'h3C);
    rchk(12'hE62, 8'h40);
    wr(12'hE63, 8'h00);
    wr(12'hE62, 8'h60);
    wait_idle();
    rchk(12'hE64, 8'h00);
    wr(12'hE63, 8'h49);
    col(2'h1, 3'h1, 3'h1, cv(1, 1, 1, ETM_E1_TU12, ETM_MAP_ASYNC, 0, 0),
        1'b1, {1'b0, 2'h1, 5'h05});
    wr(12'hE70, 8'h01);
    col(2'h1, 3'h1, 3'h1, cv(1, 1, 1, ETM_E1_TU12, ETM_MAP_ASYNC, 0, 0),
        1'b1, {1'b1, 2'h1, 5'h05});
    wr(12'hE61, 8'h00);
    col(2'h1, 3'h1, 3'h1, cv(1, 1, 1, ETM_E1_TU12, ETM_MAP_ASYNC, 0, 0),
        1'b1, {1'b1, 2'h1, 5'h1C});
    summarize();
  end

  // ----------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------
  // the sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    summarize();
  end
endmodule : tb_egress_tributary_mapper_control
`default_nettype wire
